// ---- flag_alu.sv ----
// Flag ALU with data formats and address alignment behind an AXI4-Lite slave
//
// Decided for this implementation: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
// Behaviour
// RQ1 - Zero flag set on all-zero result, cleared otherwise.
// RQ2 - Overflow flag set on arithmetic overflow, cleared when none.
// RQ3 - Add loads carry flag with carry out of the top operand bit.
// RQ4 - Subtract and compare set carry on borrow, clear otherwise.
// RQ5 - Shifts and rotates put the shifted-out bit in the carry flag.
// RQ6 - Bit operations use the carry flag as one-bit accumulator.
// RQ7 - Sizes: bit, BCD digit, byte, word and longword.
// RQ8 - Bit operations pick bit zero to seven of a byte operand.
// RQ9 - Decimal adjust treats a byte as two packed BCD digits.
// RQ10 - Word and longword data start on even byte addresses.
// RQ11 - Odd word or longword address: no error, bit zero forced low.
// RQ12 - Instruction fetch addresses get the same bit zero forcing.
// RQ13 - Software should use only word or longword sizes on the stack.
// RQ14 - Sign flag copies the result's top bit at operand size.
// RQ15 - Half carry from bit 3, 11 or 27 for byte, word, long arithmetic.
// RQ16 - Flags an operation does not affect keep their old values.
// RQ17 - Fetch ignores the counter's lowest bit, treating it as zero.
// RQ18 - Overflow follows two's-complement sign rules.
module flag_alu (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write address channel
	input  wire logic [31:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        awvalid,
	output logic             awready,
	// Write data channel
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// Write response channel
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// Read address channel
	input  wire logic [31:0] araddr,
	input  wire logic [2:0]  arprot,
	input  wire logic        arvalid,
	output logic             arready,
	// Read data channel
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// Condition code register contents
	output logic      [7:0]  condition_code_register
);
	// ==========================================================
	// Declarations
	logic                       aw_have_q;
	logic [31:0]                aw_addr_q;
	logic                       w_have_q;
	logic [31:0]                w_data_q;
	logic [3:0]                 w_strb_q;
	logic                       bvalid_q;
	logic [1:0]                 bresp_q;
	logic                       rvalid_q;
	logic [1:0]                 rresp_q;
	logic [31:0]                rdata_q;
	logic                       aw_fire;
	logic                       w_fire;
	logic                       wr_go;
	logic [31:0]                wr_addr;
	logic [31:0]                wr_data;
	logic [3:0]                 wr_strb;
	logic                       wr_hit;
	logic                       rd_hit;
	logic [31:0]                rd_mux;
	logic [31:0]                ctrl_q;
	logic [31:0]                opa_q;
	logic [31:0]                opb_q;
	logic [31:0]                result_q;
	logic [7:0]                 flags_q;
	logic [7:0]                 flags_d;
	logic [23:0]                addr_in_q;
	logic [31:0]                addr_in_m;
	logic [23:0]                addr_out;
	logic                       addr_odd;
	logic                       exec_q;
	flag_alu_pkg::alu_op_t      op;
	flag_alu_pkg::op_size_t     size;
	logic [2:0]                 bidx;
	logic [1:0]                 kind;
	logic [4:0]                 msb;
	logic [4:0]                 hb;
	logic [5:0]                 cb;
	logic [31:0]                mask;
	logic [31:0]                top_bit;
	logic [31:0]                a_m;
	logic [31:0]                b_m;
	logic [31:0]                sub_a;
	logic [31:0]                sub_b;
	logic [32:0]                sum33;
	logic [32:0]                dif33;
	logic [31:0]                hv_add;
	logic [31:0]                hv_sub;
	logic [31:0]                shr;
	logic [31:0]                shl;
	logic [31:0]                res;
	logic [31:0]                res_full;
	logic [7:0]                 flg;
	logic [7:0]                 upd;
	logic                       wr_res;
	logic                       bit_val;
	logic [7:0]                 bcd_val;
	logic                       bcd_c;

	// Merges new data into a word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (st[i])
				m[8*i +: 8] = nw[8*i +: 8];
		end
		return m;
	endfunction

	// ==========================================================
	// Write channels, taken in either order
	assign awready = !aw_have_q && !bvalid_q;
	assign wready  = !w_have_q && !bvalid_q;
	assign aw_fire = awvalid && awready;
	assign w_fire  = wvalid && wready;
	assign wr_go   = (aw_have_q || aw_fire) && (w_have_q || w_fire);
	assign wr_addr = aw_have_q ? aw_addr_q : awaddr;
	assign wr_data = w_have_q ? w_data_q : wdata;
	assign wr_strb = w_have_q ? w_strb_q : wstrb;
	assign wr_hit  = (wr_addr == flag_alu_pkg::CTRL_OFS) || (wr_addr == flag_alu_pkg::OPA_OFS)
		|| (wr_addr == flag_alu_pkg::OPB_OFS) || (wr_addr == flag_alu_pkg::RESULT_OFS)
		|| (wr_addr == flag_alu_pkg::COND_CODE_OFS) || (wr_addr == flag_alu_pkg::ADDR_IN_OFS)
		|| (wr_addr == flag_alu_pkg::ADDR_OUT_OFS);

	// Holds an address or data beat that arrived before its partner
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
			aw_addr_q <= 32'h0000_0000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end
		else if (wr_go)
		begin
			aw_have_q <= 1'b0;
			w_have_q  <= 1'b0;
		end
		else
		begin
			if (aw_fire)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= awaddr;
			end
			if (w_fire)
			begin
				w_have_q <= 1'b1;
				w_data_q <= wdata;
				w_strb_q <= wstrb;
			end
		end
	end

	// Write response, error for unmapped addresses
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= flag_alu_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? flag_alu_pkg::RESP_OKAY : flag_alu_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid_q <= 1'b0;
	end

	assign bvalid = bvalid_q;
	assign bresp  = bresp_q;

	// ==========================================================
	// Software registers; a control write launches one operation
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctrl_q    <= flag_alu_pkg::CTRL_RESET;
			opa_q     <= flag_alu_pkg::DATA_RESET;
			opb_q     <= flag_alu_pkg::DATA_RESET;
			addr_in_q <= flag_alu_pkg::ADDR_RESET;
			exec_q    <= 1'b0;
		end
		else
		begin
			exec_q <= wr_go && (wr_addr == flag_alu_pkg::CTRL_OFS);
			if (wr_go && (wr_addr == flag_alu_pkg::CTRL_OFS))
				ctrl_q <= merge(ctrl_q, wr_data, wr_strb);
			if (wr_go && (wr_addr == flag_alu_pkg::OPA_OFS))
				opa_q <= merge(opa_q, wr_data, wr_strb);
			if (wr_go && (wr_addr == flag_alu_pkg::OPB_OFS))
				opb_q <= merge(opb_q, wr_data, wr_strb);
			if (wr_go && (wr_addr == flag_alu_pkg::ADDR_IN_OFS))
				addr_in_q <= addr_in_m[23:0];
		end
	end

	// Address input keeps only its low three bytes
	assign addr_in_m = merge({8'h00, addr_in_q}, wr_data, wr_strb);

	// ==========================================================
	// Control field decode
	assign op   = flag_alu_pkg::alu_op_t'(ctrl_q[flag_alu_pkg::OP_LSB +: flag_alu_pkg::OP_W]);
	assign size = flag_alu_pkg::op_size_t'(ctrl_q[flag_alu_pkg::SIZE_LSB +: flag_alu_pkg::SIZE_W]);
	assign bidx = ctrl_q[flag_alu_pkg::BIDX_LSB +: flag_alu_pkg::BIDX_W];
	assign kind = ctrl_q[flag_alu_pkg::KIND_LSB +: flag_alu_pkg::KIND_W];

	// Operand width; bit and BCD operands live in a byte
	always_comb
	begin
		msb  = 5'd7;
		mask = 32'h0000_00FF;
		case (size)
			flag_alu_pkg::SZ_WORD:
			begin
				msb  = 5'd15;
				mask = 32'h0000_FFFF;
			end
			flag_alu_pkg::SZ_LONG:
			begin
				msb  = 5'd31;
				mask = 32'hFFFF_FFFF;
			end
			default:
			begin
				msb  = 5'd7;
				mask = 32'h0000_00FF;
			end
		endcase
	end

	// ==========================================================
	// Adder, subtractor and shifter at operand size
	assign a_m     = opa_q & mask;
	assign b_m     = opb_q & mask;
	assign hb      = msb - 5'd3;
	assign cb      = {1'b0, msb} + 6'd1;
	assign top_bit = 32'h0000_0001 << msb;
	assign sub_a   = (op == flag_alu_pkg::OP_NEG) ? 32'h0000_0000 : a_m;
	assign sub_b   = (op == flag_alu_pkg::OP_NEG) ? a_m : b_m;
	assign sum33   = {1'b0, a_m} + {1'b0, b_m}
		+ {32'h0000_0000, (op == flag_alu_pkg::OP_ADDX) && flags_q[flag_alu_pkg::FLAG_C_BIT]};
	assign dif33   = {1'b0, sub_a} - {1'b0, sub_b}
		- {32'h0000_0000, (op == flag_alu_pkg::OP_SUBX) && flags_q[flag_alu_pkg::FLAG_C_BIT]};
	assign hv_add  = a_m ^ b_m ^ sum33[31:0];
	assign hv_sub  = sub_a ^ sub_b ^ dif33[31:0];
	assign shl     = (a_m << 1) & mask;
	assign shr     = a_m >> 1;
	assign bit_val = a_m[bidx];

	bcd_adjust u_bcd (
		.value (a_m[7:0]),
		.sub   (op == flag_alu_pkg::OP_DEC_ADJ_SUB),
		.c_in  (flags_q[flag_alu_pkg::FLAG_C_BIT]),
		.h_in  (flags_q[flag_alu_pkg::FLAG_H_BIT]),
		.adj   (bcd_val),
		.c_out (bcd_c)
	);

	// Result, new flag values and which flags the operation touches
	always_comb
	begin
		res    = a_m;
		flg    = flags_q;
		upd    = 8'h00;
		wr_res = 1'b1;
		case (op)
			flag_alu_pkg::OP_ADD, flag_alu_pkg::OP_ADDX:
			begin
				res = sum33[31:0] & mask;
				flg[flag_alu_pkg::FLAG_C_BIT] = sum33[cb];                 // see RQ3
				flg[flag_alu_pkg::FLAG_H_BIT] = hv_add[hb];                // see RQ15
				flg[flag_alu_pkg::FLAG_V_BIT] = (a_m[msb] == b_m[msb])
					&& (res[msb] != a_m[msb]);                             // see RQ2 see RQ18
				upd = 8'h2F;
			end
			flag_alu_pkg::OP_SUB, flag_alu_pkg::OP_SUBX, flag_alu_pkg::OP_CMP, flag_alu_pkg::OP_NEG:
			begin
				res = dif33[31:0] & mask;
				flg[flag_alu_pkg::FLAG_C_BIT] = dif33[cb];                 // see RQ4
				flg[flag_alu_pkg::FLAG_H_BIT] = hv_sub[hb];                // see RQ15
				flg[flag_alu_pkg::FLAG_V_BIT] = (sub_a[msb] != sub_b[msb])
					&& (res[msb] != sub_a[msb]);                           // see RQ2 see RQ18
				upd    = 8'h2F;
				wr_res = (op != flag_alu_pkg::OP_CMP);
			end
			flag_alu_pkg::OP_AND, flag_alu_pkg::OP_OR, flag_alu_pkg::OP_XOR:
			begin
				res = (op == flag_alu_pkg::OP_AND) ? (a_m & b_m)
					: (op == flag_alu_pkg::OP_OR) ? (a_m | b_m) : (a_m ^ b_m);
				flg[flag_alu_pkg::FLAG_V_BIT] = 1'b0;
				upd = 8'h0E;                                               // see RQ16
			end
			flag_alu_pkg::OP_SHLL, flag_alu_pkg::OP_ROTL:
			begin
				res = shl | ((op == flag_alu_pkg::OP_ROTL) ? {31'h0, a_m[msb]} : 32'h0000_0000);
				flg[flag_alu_pkg::FLAG_C_BIT] = a_m[msb];                  // see RQ5
				flg[flag_alu_pkg::FLAG_V_BIT] = 1'b0;
				upd = 8'h0F;
			end
			flag_alu_pkg::OP_SHLR, flag_alu_pkg::OP_SHAR, flag_alu_pkg::OP_ROTR:
			begin
				res = shr;
				if ((op == flag_alu_pkg::OP_SHAR) ? a_m[msb] : ((op == flag_alu_pkg::OP_ROTR) && a_m[0]))
					res = shr | top_bit;
				flg[flag_alu_pkg::FLAG_C_BIT] = a_m[0];                    // see RQ5
				flg[flag_alu_pkg::FLAG_V_BIT] = 1'b0;
				upd = 8'h0F;
			end
			flag_alu_pkg::OP_BLD, flag_alu_pkg::OP_BAND, flag_alu_pkg::OP_BOR, flag_alu_pkg::OP_BXOR:
			begin
				case (op)                                                  // see RQ6 see RQ8
					flag_alu_pkg::OP_BLD:  flg[flag_alu_pkg::FLAG_C_BIT] = bit_val;
					flag_alu_pkg::OP_BAND: flg[flag_alu_pkg::FLAG_C_BIT] = flags_q[flag_alu_pkg::FLAG_C_BIT] & bit_val;
					flag_alu_pkg::OP_BOR:  flg[flag_alu_pkg::FLAG_C_BIT] = flags_q[flag_alu_pkg::FLAG_C_BIT] | bit_val;
					default:               flg[flag_alu_pkg::FLAG_C_BIT] = flags_q[flag_alu_pkg::FLAG_C_BIT] ^ bit_val;
				endcase
				upd    = 8'h01;
				wr_res = 1'b0;
			end
			flag_alu_pkg::OP_BST:
			begin
				res[bidx] = flags_q[flag_alu_pkg::FLAG_C_BIT];             // see RQ6
			end
			flag_alu_pkg::OP_DEC_ADJ_ADD, flag_alu_pkg::OP_DEC_ADJ_SUB:
			begin
				res = {24'h00_0000, bcd_val};                              // see RQ9
				flg[flag_alu_pkg::FLAG_C_BIT] = bcd_c;
				upd = 8'h0D;
			end
			default:
			begin
				wr_res = 1'b0;
			end
		endcase
		flg[flag_alu_pkg::FLAG_N_BIT] = res[msb];                          // see RQ14
		flg[flag_alu_pkg::FLAG_Z_BIT] = ((res & mask) == 32'h0000_0000);   // see RQ1
	end

	// Untouched flags keep their value, upper result bits are kept (see RQ16) (see RQ7)
	assign flags_d  = (flags_q & ~upd) | (flg & upd);
	assign res_full = (opa_q & ~mask) | (res & mask);

	// ==========================================================
	// Result and condition code updates
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			result_q <= flag_alu_pkg::DATA_RESET;
		else if (exec_q && wr_res)
			result_q <= res_full;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			flags_q <= flag_alu_pkg::COND_CODE_RESET;
		else if (exec_q)
			flags_q <= flags_d;
		else if (wr_go && (wr_addr == flag_alu_pkg::COND_CODE_OFS) && wr_strb[0])
			flags_q <= wr_data[7:0];
	end

	assign condition_code_register = flags_q;

	// ==========================================================
	// Address alignment for word, longword and fetch accesses
	addr_align u_align (
		.addr_in  (addr_in_q),
		.kind     (kind),
		.addr_out (addr_out),
		.was_odd  (addr_odd)
	);

	// ==========================================================
	// Read channel
	assign arready = !rvalid_q;

	always_comb
	begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		case (araddr)
			flag_alu_pkg::CTRL_OFS:      rd_mux = ctrl_q;
			flag_alu_pkg::OPA_OFS:       rd_mux = opa_q;
			flag_alu_pkg::OPB_OFS:       rd_mux = opb_q;
			flag_alu_pkg::RESULT_OFS:    rd_mux = result_q;
			flag_alu_pkg::COND_CODE_OFS: rd_mux = {24'h00_0000, flags_q};
			flag_alu_pkg::ADDR_IN_OFS:   rd_mux = {8'h00, addr_in_q};
			flag_alu_pkg::ADDR_OUT_OFS:  rd_mux = {7'h00, addr_odd, addr_out};
			default:                     rd_hit = 1'b0;
		endcase
	end

	// Read data is captured when the address is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rresp_q  <= flag_alu_pkg::RESP_OKAY;
			rdata_q  <= 32'h0000_0000;
		end
		else if (arvalid && arready)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= rd_hit ? flag_alu_pkg::RESP_OKAY : flag_alu_pkg::RESP_SLVERR;
			rdata_q  <= rd_mux;
		end
		else if (rready)
			rvalid_q <= 1'b0;
	end

	assign rvalid = rvalid_q;
	assign rresp  = rresp_q;
	assign rdata  = rdata_q;
endmodule

// ---- flag_alu_pkg.sv ----
// Package with register map, field layout and operation codes of the flag ALU
package flag_alu_pkg;

	// ==========================================================
	// Register byte offsets
	localparam logic [31:0] CTRL_OFS      = 32'h0000_0000;
	localparam logic [31:0] OPA_OFS       = 32'h0000_0004;
	localparam logic [31:0] OPB_OFS       = 32'h0000_0008;
	localparam logic [31:0] RESULT_OFS    = 32'h0000_000C;
	localparam logic [31:0] COND_CODE_OFS = 32'h0000_0010;
	localparam logic [31:0] ADDR_IN_OFS   = 32'h0000_0014;
	localparam logic [31:0] ADDR_OUT_OFS  = 32'h0000_0018;

	// ==========================================================
	// Reset values
	localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
	localparam logic [31:0] DATA_RESET      = 32'h0000_0000;
	localparam logic [7:0]  COND_CODE_RESET = 8'h80;
	localparam logic [23:0] ADDR_RESET      = 24'h00_0000;

	// ==========================================================
	// Condition code bit positions
	localparam int unsigned FLAG_I_BIT = 7;
	localparam int unsigned FLAG_H_BIT = 5;
	localparam int unsigned FLAG_N_BIT = 3;
	localparam int unsigned FLAG_Z_BIT = 2;
	localparam int unsigned FLAG_V_BIT = 1;
	localparam int unsigned FLAG_C_BIT = 0;

	// ==========================================================
	// Control register fields
	localparam int unsigned OP_LSB   = 0;
	localparam int unsigned OP_W     = 5;
	localparam int unsigned SIZE_LSB = 8;
	localparam int unsigned SIZE_W   = 3;
	localparam int unsigned BIDX_LSB = 12;
	localparam int unsigned BIDX_W   = 3;
	localparam int unsigned KIND_LSB = 16;
	localparam int unsigned KIND_W   = 2;

	// ==========================================================
	// Address alignment and bus answers
	localparam int unsigned ADDR_W       = 24;
	localparam int unsigned ADDR_ODD_BIT = 24;
	localparam logic [1:0]  RESP_OKAY    = 2'b00;
	localparam logic [1:0]  RESP_SLVERR  = 2'b10;

	// ==========================================================
	// Packed BCD correction constants
	localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
	localparam logic [7:0] BCD_BYTE_MAX  = 8'h99;
	localparam logic [7:0] BCD_LOW_ADJ   = 8'h06;
	localparam logic [7:0] BCD_HIGH_ADJ  = 8'h60;

	// ==========================================================
	// Types
	typedef enum logic [4:0] {
		OP_ADD  = 5'h00, OP_ADDX = 5'h01, OP_SUB  = 5'h02, OP_SUBX = 5'h03,
		OP_CMP  = 5'h04, OP_NEG  = 5'h05, OP_AND  = 5'h06, OP_OR   = 5'h07,
		OP_XOR  = 5'h08, OP_SHLL = 5'h09, OP_SHLR = 5'h0A, OP_SHAR = 5'h0B,
		OP_ROTL = 5'h0C, OP_ROTR = 5'h0D, OP_BLD  = 5'h0E, OP_BST  = 5'h0F,
		OP_BAND = 5'h10, OP_BOR  = 5'h11, OP_BXOR = 5'h12,
		OP_DEC_ADJ_ADD = 5'h13, OP_DEC_ADJ_SUB = 5'h14
	} alu_op_t;

	typedef enum logic [2:0] {
		SZ_BIT = 3'h0, SZ_BCD = 3'h1, SZ_BYTE = 3'h2, SZ_WORD = 3'h3, SZ_LONG = 3'h4
	} op_size_t;

	typedef enum logic [1:0] {
		ACC_BYTE = 2'h0, ACC_WORD = 2'h1, ACC_LONG = 2'h2, ACC_FETCH = 2'h3
	} access_t;

endpackage

// ---- bcd_adjust.sv ----
// Decimal adjust of a packed two-digit BCD byte after add or subtract
`timescale 1ns/1ps
module bcd_adjust (
	// Operand and incoming flags
	input  wire logic [7:0] value,
	input  wire logic       sub,
	input  wire logic       c_in,
	input  wire logic       h_in,
	// Adjusted byte and carry
	output logic      [7:0] adj,
	output logic            c_out
);
	logic       lo_fix;
	logic       hi_fix;
	logic [7:0] corr;

	// Upper and lower nibble are corrected as separate digits (see RQ9)
	always_comb
	begin
		lo_fix = h_in | (!sub && (value[3:0] > flag_alu_pkg::BCD_DIGIT_MAX));
		hi_fix = c_in | (!sub && (value > flag_alu_pkg::BCD_BYTE_MAX));
		corr   = (hi_fix ? flag_alu_pkg::BCD_HIGH_ADJ : 8'h00)
			| (lo_fix ? flag_alu_pkg::BCD_LOW_ADJ : 8'h00);
		adj    = sub ? (value - corr) : (value + corr);
		c_out  = sub ? c_in : hi_fix;
	end
endmodule

// ---- addr_align.sv ----
// Forces even addresses for word, longword and fetch accesses
`timescale 1ns/1ps
module addr_align (
	// Raw address and access kind
	input  wire logic [23:0] addr_in,
	input  wire logic [1:0]  kind,
	// Aligned address and odd indication
	output logic      [23:0] addr_out,
	output logic             was_odd
);
	logic force_even;

	// No address error exists; bit zero is simply dropped (see RQ10) (see RQ11) (see RQ12) (see RQ17)
	always_comb
	begin
		force_even = (kind != flag_alu_pkg::ACC_BYTE);
		addr_out   = {addr_in[23:1], addr_in[0] & !force_even};
		was_odd    = addr_in[0] & force_even;
	end
endmodule

// ---- flag_alu_properties.sv ----
// Concurrent checks on the flag ALU bus handshakes and flag register
`timescale 1ns/1ps
// ==========================================================
// Checker module
module flag_alu_properties (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write channels
	input  wire logic        awvalid,
	input  wire logic        awready,
	input  wire logic        wvalid,
	input  wire logic        wready,
	input  wire logic [1:0]  bresp,
	input  wire logic        bvalid,
	input  wire logic        bready,
	// Read channels
	input  wire logic        arvalid,
	input  wire logic        arready,
	input  wire logic [31:0] rdata,
	input  wire logic [1:0]  rresp,
	input  wire logic        rvalid,
	input  wire logic        rready,
	// Flag byte
	input  wire logic [7:0]  condition_code_register
);
	default clocking main_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Write answer comes one cycle after both beats and stands until taken
	write_resp_a: assert property (awvalid && awready && wvalid && wready |=> bvalid)
		else $error("write answer late");
	write_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	write_done_a: assert property (bvalid && bready |=> !bvalid)
		else $error("write answer not released");
	write_refuse_a: assert property (bvalid |-> !awready && !wready)
		else $error("write beat accepted during answer");
	// Read answer comes one cycle after the address and stands until taken
	read_resp_a: assert property (arvalid && arready |=> rvalid)
		else $error("read answer late");
	read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer changed while waiting");
	read_refuse_a: assert property (rvalid |-> !arready)
		else $error("read address accepted during answer");
	// Flags move only on a register write or the execute that follows it
	flag_hold_a: assert property (!$stable(condition_code_register) |-> $past(bvalid || wvalid || awvalid))
		else $error("flags changed without a write");
	mask_hold_a: assert property (!$stable(condition_code_register[7]) |-> $past(wvalid || awvalid))
		else $error("mask bit changed by an operation");
endmodule

bind flag_alu flag_alu_properties flag_alu_properties_inst (
	.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
	.bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
	.rresp(rresp), .rvalid(rvalid), .rready(rready), .condition_code_register(condition_code_register)
);

// ---- cpu_flags_and_data_alignment_test.sv ----
// Self-checking bench for the flag ALU over its register bus
`timescale 1ns/1ps
// ==========================================================
// Bench top
module cpu_flags_and_data_alignment_test;

	// Bus signals
	logic        aclk    = 1'b0;
	logic        aresetn = 1'b0;
	logic [31:0] awaddr  = 32'h0;
	logic        awvalid = 1'b0;
	logic [31:0] wdata   = 32'h0;
	logic [3:0]  wstrb   = 4'hF;
	logic        wvalid  = 1'b0;
	logic        bready  = 1'b0;
	logic [31:0] araddr  = 32'h0;
	logic        arvalid = 1'b0;
	logic        rready  = 1'b0;
	logic        awready;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic [7:0]  condition_code_register;
	int          failures  = 0;
	int          cmp_count = 0;
	int          cycles    = 0;

	// Clock of 5 ns period
	always #2.5 aclk = ~aclk;

	flag_alu flag_alu_inst (
		.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.condition_code_register(condition_code_register)
	);

	// ==========================================================
	// Comparison and verdict
	task check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			failures++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task print_verdict;
		if (failures == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Hang guard
	always @(posedge aclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			failures++;
			$display("mismatch at %0t: timeout", $time);
			print_verdict;
		end
	end

	// ==========================================================
	// Bus tasks: every handshake is judged at the rising edge
	task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er = flag_alu_pkg::RESP_OKAY);
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask

	task rd(input logic [31:0] a, input logic [31:0] ed, input logic [1:0] er = flag_alu_pkg::RESP_OKAY);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		check(rdata, ed);
		check({30'h0, rresp}, {30'h0, er});
	endtask

	// Loads flags and operands, runs one operation, checks flags and, except for CMP, BLD, BAND, BOR and BXOR, the result
	task exec(input logic [4:0] op, input logic [2:0] sz, input logic [2:0] bi, input logic [31:0] a,
		input logic [31:0] b, input logic [7:0] pre, input logic [31:0] res, input logic [7:0] cc);
		wr(flag_alu_pkg::COND_CODE_OFS, {24'h0, pre});
		wr(flag_alu_pkg::OPA_OFS, a);
		wr(flag_alu_pkg::OPB_OFS, b);
		wr(flag_alu_pkg::CTRL_OFS, {17'h0, bi, 1'b0, sz, 3'h0, op});
		if (!(op inside {5'h04, 5'h0E, 5'h10, 5'h11, 5'h12}))
			rd(flag_alu_pkg::RESULT_OFS, res);
		rd(flag_alu_pkg::COND_CODE_OFS, {24'h0, cc});
		check({24'h0, condition_code_register}, {24'h0, cc});
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		// Reset values, unmapped place answers with an error
		for (int a = 0; a < 32; a += 4)
			rd(a[31:0], (a == 16) ? 32'h80 : 32'h0, (a == 28) ? flag_alu_pkg::RESP_SLVERR : flag_alu_pkg::RESP_OKAY);
		wr(32'h0000_0020, 32'hFFFF_FFFF, flag_alu_pkg::RESP_SLVERR);
		// Arithmetic at byte, word and longword sizes
		exec(5'h00, 3'h2, 3'h0, 32'h1234567F, 32'h00000001, 8'h00, 32'h12345680, 8'h2A);
		exec(5'h00, 3'h3, 3'h0, 32'hABCDFFFF, 32'h00000001, 8'h00, 32'hABCD0000, 8'h25);
		exec(5'h02, 3'h4, 3'h0, 32'h00000000, 32'h00000001, 8'h00, 32'hFFFFFFFF, 8'h29);
		exec(5'h04, 3'h4, 3'h0, 32'h80000000, 32'h00000001, 8'h00, 32'h0, 8'h22);
		exec(5'h05, 3'h2, 3'h0, 32'h00000080, 32'h00000080, 8'h00, 32'h00000080, 8'h0B);
		exec(5'h01, 3'h2, 3'h0, 32'h000000FF, 32'h00000000, 8'h01, 32'h00000000, 8'h25);
		exec(5'h03, 3'h2, 3'h0, 32'h00000000, 32'h00000000, 8'h01, 32'h000000FF, 8'h29);
		// Logic operations keep carry and half carry
		exec(5'h06, 3'h3, 3'h0, 32'h0000F0F0, 32'h00008080, 8'hFF, 32'h00008080, 8'hF9);
		exec(5'h07, 3'h2, 3'h0, 32'h12345600, 32'h00000000, 8'h21, 32'h12345600, 8'h25);
		exec(5'h08, 3'h2, 3'h0, 32'h00000055, 32'h000000AA, 8'h00, 32'h000000FF, 8'h08);
		// Shifts and rotates
		exec(5'h09, 3'h2, 3'h0, 32'h00000081, 32'h00000081, 8'hFF, 32'h00000002, 8'hF1);
		exec(5'h0A, 3'h2, 3'h0, 32'h00000001, 32'h00000001, 8'h00, 32'h00000000, 8'h05);
		exec(5'h0B, 3'h2, 3'h0, 32'h00000081, 32'h00000081, 8'h00, 32'h000000C0, 8'h09);
		exec(5'h0C, 3'h2, 3'h0, 32'h00000081, 32'h00000081, 8'h00, 32'h00000003, 8'h01);
		exec(5'h0D, 3'h2, 3'h0, 32'h00000001, 32'h00000001, 8'h00, 32'h00000080, 8'h09);
		// Bit operations on the carry accumulator, bit index at both ends
		exec(5'h0E, 3'h0, 3'h7, 32'h00000080, 32'h00000080, 8'h2E, 32'h0, 8'h2F);
		exec(5'h0F, 3'h0, 3'h0, 32'h00000000, 32'h00000000, 8'h01, 32'h00000001, 8'h01);
		exec(5'h10, 3'h0, 3'h3, 32'h00000000, 32'h00000000, 8'hFF, 32'h0, 8'hFE);
		exec(5'h11, 3'h0, 3'h2, 32'h00000004, 32'h00000004, 8'h00, 32'h0, 8'h01);
		exec(5'h12, 3'h0, 3'h5, 32'h00000020, 32'h00000020, 8'h01, 32'h0, 8'h00);
		// Decimal adjust on two packed digits
		exec(5'h13, 3'h1, 3'h0, 32'h0000009A, 32'h0000009A, 8'h02, 32'h00000000, 8'h07);
		exec(5'h14, 3'h1, 3'h0, 32'h0000001F, 32'h0000001F, 8'h20, 32'h00000019, 8'h20);
		// Read-only result ignores writes, flag byte needs its strobe
		wr(flag_alu_pkg::RESULT_OFS, 32'hFFFF_FFFF);
		rd(flag_alu_pkg::RESULT_OFS, 32'h00000019);
		wstrb <= 4'hE;
		wr(flag_alu_pkg::COND_CODE_OFS, 32'h0000_00FF);
		wstrb <= 4'hF;
		rd(flag_alu_pkg::COND_CODE_OFS, 32'h0000_0020);
		// Address forcing per access kind, unknown operation leaves flags alone
		wr(flag_alu_pkg::ADDR_IN_OFS, 32'h0000_1235);
		for (int k = 0; k < 4; k++)
		begin
			wr(flag_alu_pkg::CTRL_OFS, {14'h0, k[1:0], 11'h0, 5'h1F});
			rd(flag_alu_pkg::ADDR_OUT_OFS, (k == 0) ? 32'h0000_1235 : 32'h0100_1234);
		end
		rd(flag_alu_pkg::COND_CODE_OFS, 32'h0000_0020);
		print_verdict;
	end
endmodule
